// ==== rtl/gpp_port.sv ====
/*
 * configurable 8-bit general purpose port: direction, option and data
 * latches written by the cpu, pin cells per bit, and interrupt detection
 * with selectable trigger and global enable.
 * assumes one clock, synchronous active high reset, pins already
 * synchronous to clk_sys, and a cpu that strobes one write per cycle.
 */
// Overview of operation
// - input direction: read returns pad level
// - output direction: write latches, read returns latch
// - 000 gives input with pull-up, no interrupt
// - 001 gives input, no pull-up, no interrupt
// - 010 gives pull-up input feeding interrupts
// - 011 gives analog input where available
// - direction 1, option 0: open drain
// - direction 1, option 1: push-pull
// - open drain: data 1 leaves pin floating
// - interrupt needs irq mode and global enable
// - falling, rising or low trigger per port
// - analog pins feed converter input selection
// - peripherals never select pins by themselves
// - low power leaves pins; interrupts wake
// - four low pins sink high current
// - reset clears all three registers
// - bit n controls pin n
`timescale 1ns/100ps

module gpp_port
    import gpp_pkg::*;
#(
    parameter int         WIDTH      = GPP_WIDTH,       // pins in the port
    parameter logic [7:0] ANALOG_CAP = GPP_ANALOG_CAP,  // analog capable pins
    parameter logic [7:0] HSINK_CAP  = GPP_HSINK_CAP    // high sink pins
) (
    input  wire logic             clk_sys,             // system clock
    input  wire logic             sys_rst,             // sync reset, active high
    input  wire logic             dir_wr,              // write direction latches
    input  wire logic             opt_wr,              // write option latches
    input  wire logic             pin_data_bits_wr,    // write data latches
    input  wire logic [WIDTH-1:0] wr_data,             // cpu write data
    output      logic [WIDTH-1:0] dir_rd,              // direction readback
    output      logic [WIDTH-1:0] opt_rd,              // option readback
    output      logic [WIDTH-1:0] pin_data_bits_rd,    // data read value
    input  wire logic             global_irq_enable,   // enable bit of irq option reg
    input  wire logic [1:0]       trig_mode,           // port trigger selection
    input  wire logic             low_power,           // wait or stop active
    input  wire logic [WIDTH-1:0] pin_in,              // pad input levels
    output      logic [WIDTH-1:0] pin_out,             // pad output levels
    output      logic [WIDTH-1:0] pin_oe_n,            // pad drive enable, low drives
    output      logic [WIDTH-1:0] pullup_en,           // pull-up enables
    output      logic [WIDTH-1:0] high_sink,           // high sink drive selected
    output      logic [WIDTH-1:0] analog_sel,          // converter input selection
    output      logic             port_irq,            // interrupt request pulse or level
    output      logic             wake_req             // wake request in low power
);

    logic [WIDTH-1:0] dir_bits;                        // direction latches
    logic [WIDTH-1:0] opt_bits;                        // option latches
    logic [WIDTH-1:0] pin_data_bits;                   // data latches
    logic [WIDTH-1:0] irq_src;                         // pins in interrupt mode
    logic [WIDTH-1:0] read_bits;                       // per-pin read value
    logic [WIDTH-1:0] pin_prev;                        // last sampled pad level
    logic [WIDTH-1:0] src_prev;                        // last interrupt eligibility
    logic [WIDTH-1:0] hit;                             // per-pin trigger match
    logic             next_irq;                        // next interrupt output

    // direction latches, cleared on reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dir_bits <= GPP_DIR_RST;
        end else if (dir_wr) begin
            dir_bits <= wr_data;
        end
    end

    // option latches, cleared on reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            opt_bits <= GPP_OPT_RST;
        end else if (opt_wr) begin
            opt_bits <= wr_data;
        end
    end

    // data latches; written whatever the direction, since inputs use them
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_data_bits <= GPP_DATA_RST;
        end else if (pin_data_bits_wr) begin
            pin_data_bits <= wr_data;
        end
    end

    // one cell per pin; only the latches steer the pads, no peripheral
    // request takes a pin over
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            gpp_pin_cell #(
                .ANALOG_OK (ANALOG_CAP[gi])
            ) u_cell (
                .dir_bit    (dir_bits[gi]),
                .opt_bit    (opt_bits[gi]),
                .data_bit   (pin_data_bits[gi]),
                .pin_in     (pin_in[gi]),
                .pin_out    (pin_out[gi]),
                .pin_oe_n   (pin_oe_n[gi]),
                .pullup_en  (pullup_en[gi]),
                .analog_sel (analog_sel[gi]),
                .irq_src    (irq_src[gi]),
                .read_bit   (read_bits[gi]),
                .mode       ()
            );
            // high sink only applies while the pin is an output, open drain included
            assign high_sink[gi] = HSINK_CAP[gi] && dir_bits[gi];
        end
    endgenerate

    assign dir_rd           = dir_bits;
    assign opt_rd           = opt_bits;
    assign pin_data_bits_rd = read_bits;

    // history of pad levels and eligibility for edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_prev <= '1;
            src_prev <= '0;
        end else begin
            pin_prev <= pin_in;
            src_prev <= irq_src;
        end
    end

    // trigger match; an edge counts only if the pin was already eligible
    always_comb begin
        hit = '0;
        unique case (trig_mode)
            GPP_TRIG_FALL: hit = pin_prev & ~pin_in & src_prev;
            GPP_TRIG_RISE: hit = ~pin_prev & pin_in & src_prev;
            GPP_TRIG_LOW:  hit = ~pin_in;
            default:       hit = '0;                              // unused code
        endcase
        next_irq = global_irq_enable && |(hit & irq_src);
    end

    // registered request; pins keep their state through low power
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            port_irq <= 1'b0;
        end else begin
            port_irq <= next_irq;
        end
    end

    // wake only from low power, and only with interrupts enabled
    assign wake_req = low_power && port_irq;

endmodule : gpp_port

// ==== rtl/gpp_pkg.sv ====
/*
 * constants for the configurable 8-bit general purpose port: widths,
 * reset values and the pin mode enumeration.
 * assumes nothing beyond a systemverilog compiler.
 */
package gpp_pkg;

    localparam int          GPP_WIDTH      = 8;         // pins in one port
    localparam logic [7:0]  GPP_DIR_RST    = 8'h00;     // direction reset value
    localparam logic [7:0]  GPP_OPT_RST    = 8'h00;     // option reset value
    localparam logic [7:0]  GPP_DATA_RST   = 8'h00;     // data latch reset value
    localparam logic [7:0]  GPP_ANALOG_CAP = 8'hFF;     // pins with analog capability
    localparam logic [7:0]  GPP_HSINK_CAP  = 8'h0F;     // pins with high sink drive
    localparam logic [1:0]  GPP_TRIG_FALL  = 2'h0;      // falling edge trigger code
    localparam logic [1:0]  GPP_TRIG_RISE  = 2'h1;      // rising edge trigger code
    localparam logic [1:0]  GPP_TRIG_LOW   = 2'h2;      // low level trigger code

    // per-pin operating mode decoded from direction, option and data
    typedef enum logic [2:0] {
        GPP_IN_PULLUP,
        GPP_IN_FLOAT,
        GPP_IN_IRQ,
        GPP_IN_ANALOG,
        GPP_OUT_OD,
        GPP_OUT_PP
    } gpp_mode_t;

endpackage : gpp_pkg

// ==== rtl/gpp_pin_cell.sv ====
/*
 * one pin of the port: decodes its mode from the three control bits and
 * drives pad enables, pull-up, analog select and the interrupt source.
 * assumes pin_in is already synchronous to clk_sys.
 */
`timescale 1ns/100ps

module gpp_pin_cell
    import gpp_pkg::*;
#(
    parameter bit ANALOG_OK = 1'b1                   // pin has a converter path
) (
    input  wire logic      dir_bit,                  // direction control bit
    input  wire logic      opt_bit,                  // option control bit
    input  wire logic      data_bit,                 // data latch bit
    input  wire logic      pin_in,                   // pad input level
    output      logic      pin_out,                  // pad output level
    output      logic      pin_oe_n,                 // pad drive enable, low drives
    output      logic      pullup_en,                // pull-up enable
    output      logic      analog_sel,               // route pad to converter
    output      logic      irq_src,                  // pin eligible for interrupt
    output      logic      read_bit,                 // value seen by a data read
    output      gpp_mode_t mode                      // decoded mode
);

    // mode decode, one row per mode
    always_comb begin
        unique case ({dir_bit, opt_bit, data_bit})
            3'b000:  mode = GPP_IN_PULLUP;
            3'b001:  mode = GPP_IN_FLOAT;
            3'b010:  mode = GPP_IN_IRQ;
            3'b011:  mode = GPP_IN_ANALOG;
            3'b100,
            3'b101:  mode = GPP_OUT_OD;
            default: mode = GPP_OUT_PP;
        endcase
    end

    // pad drivers; open drain only ever drives low
    always_comb begin
        pin_out  = data_bit;
        pin_oe_n = 1'b1;
        if (mode == GPP_OUT_PP) begin
            pin_oe_n = 1'b0;
        end else if (mode == GPP_OUT_OD) begin
            pin_out  = 1'b0;
            pin_oe_n = data_bit;
        end
    end

    assign pullup_en  = (mode == GPP_IN_PULLUP) || (mode == GPP_IN_IRQ);
    assign analog_sel = ANALOG_OK && (mode == GPP_IN_ANALOG);
    assign irq_src    = (mode == GPP_IN_IRQ);
    // inputs read the pad, outputs read the latch
    assign read_bit   = dir_bit ? data_bit : pin_in;

endmodule : gpp_pin_cell

// ==== verif/gpp_ext_model.sv ====
/* external circuitry on the port pins: a driver per pin and pull-ups.
 * assumes pad enables from the port; a pin driven by nobody wanders. */
`timescale 1ns/100ps

module gpp_ext_model (
    input  wire logic       clk_sys,                  // system clock
    input  wire logic [7:0] pin_out,                  // port pad level
    input  wire logic [7:0] pin_oe_n,                 // port pad enable, low drives
    input  wire logic [7:0] pullup_en,                // port pull-up enables
    input  wire logic [7:0] ext_en,                   // external driver enables
    input  wire logic [7:0] ext_val,                  // external driver levels
    output      logic [7:0] pin_in                    // resolved pad level
);
    logic [7:0] drift = 8'h00;                        // level of undriven pins

    // an undriven pin never holds its last value
    always_ff @(posedge clk_sys) begin
        drift <= ~pin_in;
    end
    // port drive, else external drive, else pull-up, else wander
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & (pullup_en | drift));
endmodule : gpp_ext_model

// ==== verif/gpp_port_monitor.sv ====
/* concurrent checks on the port's pins, latches and interrupt.
 * assumes one clock and synchronous active high reset. */
`timescale 1ns/100ps

module gpp_port_monitor
    import gpp_pkg::*;
#(
    parameter int         WIDTH      = GPP_WIDTH,
    parameter logic [7:0] ANALOG_CAP = GPP_ANALOG_CAP
) (
    input wire logic             clk_sys,            // system clock
    input wire logic             sys_rst,            // sync reset, active high
    input wire logic             dir_wr,             // direction write strobe
    input wire logic             pin_data_bits_wr,   // data write strobe
    input wire logic             global_irq_enable,  // interrupt enable
    input wire logic             low_power,          // wait or stop active
    input wire logic             port_irq,           // interrupt request
    input wire logic             wake_req,           // wake request
    input wire logic [WIDTH-1:0] wr_data,            // cpu write data
    input wire logic [WIDTH-1:0] dir_rd,             // direction readback
    input wire logic [WIDTH-1:0] opt_rd,             // option readback
    input wire logic [WIDTH-1:0] pin_data_bits_rd,   // data read value
    input wire logic [WIDTH-1:0] pin_in,             // pad input levels
    input wire logic [WIDTH-1:0] pin_out,            // pad output levels
    input wire logic [WIDTH-1:0] pin_oe_n,           // pad drive enable, low drives
    input wire logic [WIDTH-1:0] pullup_en,          // pull-up enables
    input wire logic [WIDTH-1:0] analog_sel          // converter input selection
);
    logic [WIDTH-1:0] dsh;                   // copy of the data latches

    // inputs hide the data latch on reads, so keep a copy
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dsh <= '0;
        end else if (pin_data_bits_wr) begin
            dsh <= wr_data;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_reset_pullup: assert property ($fell(sys_rst) |-> pin_oe_n == '1 && pullup_en == '1)
        else $error("reset state wrong");
    a_dir_write: assert property (dir_wr |=> dir_rd == $past(wr_data))
        else $error("direction write lost");
    a_input_read: assert property ((pin_data_bits_rd & ~dir_rd) == (pin_in & ~dir_rd))
        else $error("input read wrong");
    a_output_read: assert property ((pin_data_bits_rd & dir_rd) == (dsh & dir_rd))
        else $error("output read wrong");
    a_push_pull: assert property (((pin_oe_n | (pin_out ^ dsh)) & dir_rd & opt_rd) == '0)
        else $error("push-pull drive wrong");
    a_open_drain: assert property ((((pin_oe_n ^ dsh) | pin_out) & dir_rd & ~opt_rd) == '0)
        else $error("open drain drive wrong");
    a_pullup_mode: assert property (pullup_en == (~dir_rd & ~dsh))
        else $error("pull-up wrong");
    a_analog_mode: assert property (analog_sel == (~dir_rd & opt_rd & dsh & ANALOG_CAP))
        else $error("analog select wrong");
    a_irq_gen: assert property (!global_irq_enable |=> !port_irq)
        else $error("irq without enable");
    a_wake_irq: assert property (wake_req == (low_power && port_irq))
        else $error("wake wrong");
    c_irq: cover property (port_irq);
    c_wake: cover property (wake_req);
    c_analog: cover property (analog_sel != '0);
endmodule : gpp_port_monitor

bind gpp_port gpp_port_monitor #(.WIDTH(WIDTH), .ANALOG_CAP(ANALOG_CAP)) gpp_port_monitor_i (
    .clk_sys, .sys_rst, .dir_wr, .pin_data_bits_wr, .global_irq_enable, .low_power, .port_irq,
    .wake_req, .wr_data, .dir_rd, .opt_rd, .pin_data_bits_rd, .pin_in, .pin_out, .pin_oe_n,
    .pullup_en, .analog_sel);

// ==== verif/gpp_port_tb.sv ====
/* testbench of the port: reset state, mode table, readback, interrupts.
 * assumes the external model on the pins and the bound checker. */
`timescale 1ns/100ps

module gpp_port_tb import gpp_pkg::*;;
    logic       clk_sys = 1'b0, sys_rst = 1'b1, dir_wr = 1'b0, opt_wr = 1'b0;
    logic       pin_data_bits_wr = 1'b0, global_irq_enable = 1'b0, low_power = 1'b0;
    logic [1:0] trig_mode = 2'h3;
    logic [7:0] wr_data = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [7:0] dir_rd, opt_rd, pin_data_bits_rd, pin_in, pin_out, pin_oe_n;
    logic [7:0] pullup_en, high_sink, analog_sel;
    logic       port_irq, wake_req;
    int         n_fail = 0, tests_run = 0;

    gpp_port gpp_port_i (.clk_sys, .sys_rst, .dir_wr, .opt_wr, .pin_data_bits_wr, .wr_data,
        .dir_rd, .opt_rd, .pin_data_bits_rd, .global_irq_enable, .trig_mode, .low_power,
        .pin_in, .pin_out, .pin_oe_n, .pullup_en, .high_sink, .analog_sel, .port_irq, .wake_req);
    gpp_ext_model gpp_ext_model_i (.clk_sys, .pin_out, .pin_oe_n, .pullup_en, .ext_en, .ext_val,
        .pin_in);

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // whole-byte write, strobes picked by sel = {dir, opt, data}
    task automatic wr(input logic [2:0] sel, input logic [7:0] val);
        @(negedge clk_sys);
        {dir_wr, opt_wr, pin_data_bits_wr} = sel;
        wr_data = val;
        @(negedge clk_sys);
        {dir_wr, opt_wr, pin_data_bits_wr} = 3'h0;
    endtask : wr

    // set pad levels, then judge the interrupt one edge later
    task automatic step(input logic [7:0] v, input logic e);
        ext_val = v;
        @(negedge clk_sys);
        chk("port_irq", {7'h00, e}, {7'h00, port_irq});
    endtask : step

    task automatic t_reset;
        chk("dir_rd", 8'h00, dir_rd | opt_rd);
        chk("pin_oe_n", 8'hFF, pin_oe_n);
        chk("pullup_en", 8'hFF, pullup_en);
        chk("rd", 8'hFF, pin_data_bits_rd);
        chk("analog_sel", 8'h00, analog_sel | port_irq);
    endtask : t_reset

    // one pin per {dir, opt, data} code: dir F0, opt CC, data AA; one analog pin only
    task automatic t_modes;
        ext_en = 8'h0F;
        ext_val = 8'h06;
        wr(3'h1, 8'hAA);
        wr(3'h2, 8'hCC);
        wr(3'h4, 8'hF0);
        chk("opt_rd", 8'hCC, opt_rd);
        chk("pin_oe_n", 8'h2F, pin_oe_n);
        chk("pin_out", 8'h8A, pin_out);
        chk("pullup_en", 8'h05, pullup_en);
        chk("analog_sel", 8'h08, analog_sel);
        chk("rd", 8'hA6, pin_data_bits_rd);
        chk("high_sink", 8'h00, high_sink);
        ext_en = 8'h00;
        wr(3'h4, 8'h0F);
        ext_en = 8'hF0;
        ext_val = 8'h50;
        chk("high_sink", 8'h0F, high_sink);
        chk("pin_oe_n", 8'hF2, pin_oe_n);
        chk("pin_out", 8'hA8, pin_out);
        chk("pullup_en", 8'h50, pullup_en);
        chk("analog_sel", 8'h80, analog_sel);
        @(negedge clk_sys);
        chk("rd", 8'h5A, pin_data_bits_rd);
    endtask : t_modes

    // pin 2 in interrupt mode, safe order of mode changes
    task automatic t_irq;
        ext_en = 8'h04;
        ext_val = 8'h04;
        wr(3'h2, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h04);
        global_irq_enable = 1'b1;
        trig_mode = GPP_TRIG_FALL;
        step(8'h04, 1'b0);
        step(8'h00, 1'b1);
        step(8'h00, 1'b0);
        trig_mode = GPP_TRIG_RISE;
        step(8'h04, 1'b1);
        step(8'h04, 1'b0);
        trig_mode = GPP_TRIG_LOW;
        low_power = 1'b1;
        step(8'h00, 1'b1);
        step(8'h00, 1'b1);
        chk("wake_req", 8'h01, {7'h00, wake_req});
        chk("pin_oe_n", 8'hFF, pin_oe_n);
        step(8'h04, 1'b0);
        low_power = 1'b0;
        trig_mode = GPP_TRIG_FALL;
        global_irq_enable = 1'b0;
        step(8'h00, 1'b0);
        step(8'h04, 1'b0);
        global_irq_enable = 1'b1;
        ext_en = 8'h06;
        step(8'h06, 1'b0);
        step(8'h04, 1'b0);
        // upper pins taken as unbonded: written back to reset values, masked out of the read
        chk("rd_masked", 8'h0D, pin_data_bits_rd & 8'h0F);
    endtask : t_irq

    task automatic conclude;
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_reset();
        t_modes();
        t_irq();
        conclude();
    end

    initial begin
        #4000;
        n_fail++;
        conclude();
    end
endmodule : gpp_port_tb
